// *** dv/sadc_ctrl_props.sv ***
/*
 Concurrent checks on the converter control ports.
 Assumes binding to every sadc_ctrl and sight of its ports only.
*/
`timescale 1ns/1ns
`default_nettype none

module sadc_ctrl_props (
   input wire logic        i_clk,
   input wire logic        i_rst,
   input wire logic [15:0] i_ctl_one,
   input wire logic [15:0] i_ctl_two,
   input wire logic        i_flag_clear,
   input wire logic        i_dma_ready,
   input wire logic [3:0]  o_sh_track,
   input wire logic [11:0] o_dac_code,
   input wire logic [2:0]  o_vref_sel,
   input wire logic        o_busy,
   input wire logic        o_converter_interrupt_flag,
   input wire logic        o_dma_req,
   input wire logic        o_dma_valid,
   input wire logic [15:0] o_dma_data,
   input wire logic [11:0] o_dma_addr
);
   // Shadow of the latched resolution; it only follows while off
   logic res_r;
   logic res_nxt;
   always_comb res_nxt = i_ctl_one[15] ? res_r : i_ctl_one[10];
   always_ff @(posedge i_clk) res_r <= i_rst ? 1'b0 : res_nxt;

   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);

   rst_quiet_a: assert property (disable iff (1'b0) i_rst |=> !o_busy && !o_dma_valid
      && !o_converter_interrupt_flag && !o_dma_req && o_sh_track == 4'h0)
      else $error("outputs not quiet after reset");
   req_pulse_a: assert property (o_dma_req |=> !o_dma_req)
      else $error("transfer request longer than one cycle");
   req_flag_a: assert property (o_dma_req |-> o_converter_interrupt_flag)
      else $error("transfer request without flag");
   flag_hold_a: assert property (o_converter_interrupt_flag && !i_flag_clear
      |=> o_converter_interrupt_flag) else $error("flag dropped by itself");
   flag_clear_a: assert property (i_flag_clear && !o_busy
      |=> !o_converter_interrupt_flag) else $error("flag not cleared");
   word_hold_a: assert property (o_dma_valid && !i_dma_ready |=> o_dma_valid
      && $stable(o_dma_data) && $stable(o_dma_addr)) else $error("word changed while held");
   vref_follow_a: assert property (1'b1 |=> o_vref_sel == $past(i_ctl_two[15:13]))
      else $error("reference select not following");
   single_sh_a: assert property ($changed(o_sh_track)
      && (res_r || $past(i_ctl_two[9:8]) == 2'h0) |-> $onehot0(o_sh_track))
      else $error("too many sample/holds tracking");
   low_range_a: assert property (!res_r && o_busy |-> o_dac_code[11:10] == 2'h0)
      else $error("code beyond ten bits");
   conv_len_a: assert property ($rose(o_busy) |-> (o_busy || !i_ctl_one[15])[*8])
      else $error("conversion too short");
endmodule : sadc_ctrl_props

bind sadc_ctrl sadc_ctrl_props u_props (.i_clk(i_clk), .i_rst(i_rst), .i_ctl_one(i_ctl_one),
   .i_ctl_two(i_ctl_two), .i_flag_clear(i_flag_clear), .i_dma_ready(i_dma_ready),
   .o_sh_track(o_sh_track), .o_dac_code(o_dac_code), .o_vref_sel(o_vref_sel),
   .o_busy(o_busy), .o_converter_interrupt_flag(o_converter_interrupt_flag),
   .o_dma_req(o_dma_req), .o_dma_valid(o_dma_valid), .o_dma_data(o_dma_data),
   .o_dma_addr(o_dma_addr));

`default_nettype wire

// *** dv/sadc_ctrl_tb.sv ***
/*
 Self-checking bench for sadc_ctrl with an ideal comparator.
 Assumes sadc_dma_model and the bound property checker.
*/
`timescale 1ns/1ns
`default_nettype none

module sadc_ctrl_tb;
   logic        clk, rst, samp_set, samp_clear, flag_clear, cmp, cpu_idle, cpu_sleep;
   logic [15:0] ctl1, ctl2, ctl3, pc_lo, pc_hi, dma_data, m_data;
   logic [11:0] dac, dma_addr, m_addr, level;
   logic [7:0]  trig, m_count;
   logic [4:0]  ch0, ain;
   logic [3:0]  sh;
   logic [2:0]  buf_len, vref;
   logic        alt, busy, flag, req, valid, ready, stall, slow;
   int          mismatches, total_checks;
   bit          done;

   sadc_ctrl DUT (.i_clk(clk), .i_rst(rst), .i_ctl_one(ctl1), .i_ctl_two(ctl2),
      .i_ctl_three(ctl3), .i_port_config_low(pc_lo), .i_port_config_high(pc_hi),
      .i_ch0_sel(ch0), .i_ch123_alt(alt), .i_dma_buf_len(buf_len), .i_samp_set(samp_set),
      .i_samp_clear(samp_clear), .i_trig_src(trig), .i_cpu_idle(cpu_idle),
      .i_cpu_sleep(cpu_sleep), .i_flag_clear(flag_clear), .i_cmp(cmp),
      .i_dma_ready(ready), .o_ain_sel(ain), .o_sh_track(sh), .o_dac_code(dac),
      .o_vref_sel(vref), .o_busy(busy), .o_converter_interrupt_flag(flag),
      .o_dma_req(req), .o_dma_valid(valid), .o_dma_data(dma_data), .o_dma_addr(dma_addr));

   sadc_dma_model u_dma (.i_clk(clk), .i_rst(rst), .i_valid(valid), .i_data(dma_data),
      .i_addr(dma_addr), .i_stall(stall), .i_slow(slow), .o_ready(ready),
      .o_data(m_data), .o_addr(m_addr), .o_count(m_count));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Ideal comparator on a held level, settled after each edge
   always @(posedge clk) #1 cmp = (level >= dac);

   task step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   task stop_test;
      if (mismatches == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : stop_test

   task timeout;
      mismatches++;
      $display("ERROR %0t wait ran out", $time);
      stop_test;
   endtask : timeout

   task chk_val(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t value %h expected %h", $time, got, exp);
      end
   endtask : chk_val

   task chk_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t bit %b expected %b", $time, got, exp);
      end
   endtask : chk_bit

   // Manual sample, then samp_clear pulsed with all trigger lines; ok once busy drops
   task convert(output bit ok);
      samp_set = 1'b1;
      step(1);
      samp_set = 1'b0;
      step(2);
      samp_clear = 1'b1;
      trig = 8'hff;
      step(1);
      samp_clear = 1'b0;
      trig = 8'h00;
      ok = 1'b0;
      for (int i = 0; i < 100 && !ok; i++) begin
         step(1);
         ok = (busy === 1'b0);
      end
   endtask : convert

   task run;
      convert(done);
      if (!done)
         timeout;
   endtask : run

   task get(input int n);
      for (int i = 0; i < 300 && m_count !== n; i++)
         step(1);
      if (m_count !== n)
         timeout;
   endtask : get

   // Whole setup while off, then on
   task setup(input logic [15:0] c1, input logic [15:0] c2);
      ctl1 = c1 & 16'h7fff;
      ctl2 = c2;
      step(2);
      ctl1 = c1;
      step(1);
   endtask : setup

   task clr;
      flag_clear = 1'b1;
      step(1);
      flag_clear = 1'b0;
      step(1);
   endtask : clr

   function automatic logic [15:0] fmt(input logic hi, input logic [1:0] f,
                                       input logic [11:0] v);
      logic [15:0] m;
      m = hi ? 16'h0800 : 16'h0200;
      fmt = f[0] ? ({4'h0, v} ^ m) : {4'h0, v};
      if (f == 2'h1 && (fmt & m) != 16'h0)
         fmt = fmt | ~((m << 1) - 16'h0001);
      if (f[1])
         fmt = fmt << (hi ? 4 : 6);
   endfunction : fmt

   initial begin
      rst = 1'b1;
      {samp_set, samp_clear, flag_clear, cmp, cpu_idle, cpu_sleep, alt} = 7'h00;
      {stall, slow, mismatches, total_checks} = '0;
      ctl1 = 16'h0000;
      ctl2 = 16'h0000;
      ctl3 = 16'h0100;
      {pc_lo, pc_hi, trig, ch0, buf_len} = '0;
      level = 12'h2a5;
      step(2);
      rst = 1'b0;
      for (int k = 0; k < 8; k++) begin
         setup({4'h9, 1'b0, k[2], k[1:0], 8'h00}, 16'ha000);
         run;
         get(k + 1);
         chk_val(m_data, fmt(k[2], k[1:0], level));
         chk_val({4'h0, m_addr}, 16'h0000);
         chk_bit(flag, 1'b1);
         clr;
         chk_bit(flag, 1'b0);
      end
      setup(16'h9200, 16'ha000);
      ctl1 = 16'h9600;
      step(1);
      run;
      get(9);
      chk_val(m_data, fmt(1'b0, 2'h2, level));
      ch0 = 5'h05;
      buf_len = 3'h2;
      {cpu_idle, cpu_sleep} = 2'b11;
      setup(16'ha000, 16'ha000);
      for (int k = 0; k < 3; k++) begin
         run;
         get(10 + k);
         chk_val({4'h0, m_addr}, 16'h0014 + 16'(k));
         chk_val({11'h000, ain}, 16'h0005);
      end
      {cpu_idle, cpu_sleep, ch0} = '0;
      clr;
      setup(16'h9000, 16'ha00c);
      for (int k = 0; k < 4; k++) begin
         run;
         get(13 + k);
         chk_val({4'h0, m_addr}, 16'(k));
         chk_bit(flag, k == 3);
      end
      clr;
      stall = 1'b1;
      setup(16'h9000, 16'ha000);
      for (int k = 0; k < 17; k++)
         run;
      // Full buffer: the next result cannot leave its store step
      convert(done);
      chk_bit(done, 1'b0);
      stall = 1'b0;
      slow = 1'b1;
      for (int i = 0; i < 100 && busy !== 1'b0; i++)
         step(1);
      get(34);
      chk_val(m_data, {4'h0, level});
      // Four holds, alternate inputs, external trigger, auto-sample, Idle
      alt      = 1'b1;
      ch0      = 5'h10;
      cpu_idle = 1'b1;
      setup(16'h8064, 16'h6300);
      run;
      chk_val({12'h000, sh}, 16'h000f);
      chk_val({13'h0000, vref}, 16'h0003);
      get(38);
      chk_val({4'h0, m_addr}, 16'h0017);
      // Auto trigger, scan over pins 2 and 6, two clocks per Tad
      cpu_idle = 1'b0;
      pc_lo    = 16'hffbb;
      pc_hi    = 16'hffff;
      ctl3     = 16'h0101;
      setup(16'h80e4, 16'ha400);
      get(40);
      chk_val({4'h0, m_addr}, 16'h0009);
      get(41);
      chk_val({4'h0, m_addr}, 16'h001a);
      stop_test;
   end
endmodule : sadc_ctrl_tb

`default_nettype wire

// *** dv/sadc_dma_model.sv ***
/*
 Behavioural DMA channel taking converter result words.
 Assumes the valid/data/address stage of sadc_ctrl on one clock.
*/
`timescale 1ns/1ns
`default_nettype none

module sadc_dma_model (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_valid,
   input  wire logic [15:0] i_data,
   input  wire logic [11:0] i_addr,
   input  wire logic        i_stall,
   input  wire logic        i_slow,
   output logic             o_ready,
   output logic [15:0]      o_data,
   output logic [11:0]      o_addr,
   output logic [7:0]       o_count
);
   logic [1:0] ph_r;
   always @(posedge i_clk) begin
      if (i_rst) begin
         ph_r <= 2'h0;
         o_ready <= 1'b0;
         o_count <= 8'h00;
      end else begin
         ph_r <= ph_r + 2'h1;
         // Slow mode takes one word in four, like a busy bus
         o_ready <= !i_stall && (!i_slow || ph_r == 2'h3);
         if (i_valid && o_ready) begin
            o_data <= i_data;
            o_addr <= i_addr;
            o_count <= o_count + 8'h01;
         end
      end
   end
endmodule : sadc_dma_model

`default_nettype wire

// *** hw/sadc_ctrl.sv ***
/*
 Control side of one successive-approximation converter instance:
 sampling, SAR stepping, formatting, interrupt flag and DMA addressing.
 Assumes an analog comparator on i_cmp, a DMA channel taking words
 from the o_dma_* stage, and software that writes control words only
 while the module is off.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sadc_map.svh"

module sadc_ctrl (
   input  wire logic                    i_clk,
   input  wire logic                    i_rst,
   input  wire logic [15:0]             i_ctl_one,
   input  wire logic [15:0]             i_ctl_two,
   input  wire logic [15:0]             i_ctl_three,
   input  wire logic [15:0]             i_port_config_low,
   input  wire logic [15:0]             i_port_config_high,
   input  wire logic [4:0]              i_ch0_sel,
   input  wire logic                    i_ch123_alt,
   input  wire logic [2:0]              i_dma_buf_len,
   input  wire logic                    i_samp_set,
   input  wire logic                    i_samp_clear,
   input  wire logic [7:0]              i_trig_src,
   input  wire logic                    i_cpu_idle,
   input  wire logic                    i_cpu_sleep,
   input  wire logic                    i_flag_clear,
   input  wire logic                    i_cmp,
   input  wire logic                    i_dma_ready,
   output logic [4:0]                   o_ain_sel,
   output logic [3:0]                   o_sh_track,
   output logic [11:0]                  o_dac_code,
   output logic [2:0]                   o_vref_sel,
   output logic                         o_busy,
   output logic                         o_converter_interrupt_flag,
   output logic                         o_dma_req,
   output logic                         o_dma_valid,
   output logic [`SADC_DATA_W-1:0]      o_dma_data,
   output logic [`SADC_ADDR_W-1:0]      o_dma_addr
);
   localparam int FW = `SADC_DATA_W + `SADC_ADDR_W;

   sadc_pkg::sadc_state_t state_r;
   sadc_pkg::sadc_state_t state_nxt;
   logic [7:0]               tad_cnt_r;
   logic [7:0]               tad_cnt_nxt;
   logic [4:0]               samc_cnt_r;
   logic [4:0]               samc_cnt_nxt;
   logic [3:0]               bit_r;
   logic [3:0]               bit_nxt;
   logic [1:0]               sh_r;
   logic [1:0]               sh_nxt;
   logic [4:0]               scan_r;
   logic [4:0]               scan_nxt;
   logic [11:0]              dac_r;
   logic [11:0]              dac_nxt;
   logic [3:0]               grp_r;
   logic [3:0]               grp_nxt;
   logic [6:0]               ptr_r;
   logic [6:0]               ptr_nxt;
   logic                     half_r;
   logic                     half_nxt;
   logic                     res_hi_r;
   logic                     res_hi_nxt;
   logic                     flag_r;
   logic                     flag_nxt;
   logic                     req_r;
   logic                     req_nxt;
   logic [4:0]               ain_r;
   logic [4:0]               ain_nxt;
   logic [3:0]               track_r;
   logic [3:0]               track_nxt;
   logic [2:0]               vref_r;
   logic [2:0]               vref_nxt;
   logic                     ovalid_r;
   logic                     ovalid_nxt;
   logic [FW-1:0]            oword_r;
   logic [FW-1:0]            oword_nxt;
   logic                     busy_r;
   logic                     busy_nxt;

   logic                     on;
   logic                     run;
   logic                     tad_tick;
   logic                     samc_done;
   logic                     trig;
   logic [2:0]               ssrc;
   logic [1:0]               chps;
   logic [1:0]               nsh_m1;
   logic [3:0]               nbits_m1;
   logic [3:0]               sh_mask;
   logic [31:0]              analog;
   logic [4:0]               ch0_ain;
   logic [`SADC_ADDR_W-1:0]  addr;
   logic [`SADC_ADDR_W-1:0]  slot_mask;
   logic                     fifo_in_valid;
   logic                     fifo_in_ready;
   logic                     fifo_out_valid;
   logic                     fifo_out_ready;
   logic [FW-1:0]            fifo_out_data;

   // Input served by sample/hold k; channels 1..3 take a fixed triplet
   function automatic logic [4:0] ain_of(input logic [1:0] k, input logic [4:0] ch0,
                                         input logic alt);
      if (k == 2'h0) begin
         ain_of = ch0;
      end else begin
         ain_of = {3'h0, k - 2'h1} + (alt ? 5'h03 : 5'h00);
      end
   endfunction : ain_of

   // Next analog-enabled pin after cur, wrapping; stays put if none
   function automatic logic [4:0] next_scan(input logic [4:0] cur, input logic [31:0] mask);
      logic [4:0] idx;
      logic       found;
      next_scan = cur;
      found     = 1'b0;
      for (int i = 1; i <= 32; i++) begin
         idx = cur + 5'(i);
         if (!found && mask[idx]) begin
            next_scan = idx;
            found     = 1'b1;
         end
      end
   endfunction : next_scan

   // Align a raw result; raw holds n bits in its low end
   function automatic logic [15:0] fmt(input logic [11:0] raw, input logic [1:0] form,
                                       input logic hi);
      logic [11:0] sgn;
      sgn = hi ? {~raw[11], raw[10:0]} : {2'h0, ~raw[9], raw[8:0]};
      case (form)
         2'h0: fmt = {4'h0, raw};
         2'h1: fmt = hi ? {{4{sgn[11]}}, sgn} : {{6{sgn[9]}}, sgn[9:0]};
         2'h2: fmt = hi ? {raw, 4'h0} : {raw[9:0], 6'h00};
         default: fmt = hi ? {sgn, 4'h0} : {sgn[9:0], 6'h00};
      endcase
   endfunction : fmt

   always_comb begin
      on   = i_ctl_one[`SADC_C1_ON];
      // Sleep does not stop the block; only Idle with stop-in-idle set does
      run  = on && !(i_cpu_idle && !i_cpu_sleep && i_ctl_one[`SADC_C1_SIDL]);
      ssrc = i_ctl_one[`SADC_C1_SSRC_HI:`SADC_C1_SSRC_LO];
      chps = i_ctl_two[`SADC_C2_CHPS_HI:`SADC_C2_CHPS_LO];
      nbits_m1 = res_hi_r ? `SADC_BITS_HI_M1 : `SADC_BITS_LO_M1;
      if (res_hi_r) begin
         nsh_m1 = 2'h0;
      end else begin
         nsh_m1 = (chps == 2'h0) ? 2'h0 : ((chps == 2'h1) ? 2'h1 : 2'h3);
      end
      sh_mask  = (4'h2 << nsh_m1) - 4'h1;
      analog   = ~{i_port_config_high, i_port_config_low};
      ch0_ain  = i_ctl_two[`SADC_C2_SCAN] ? scan_r : i_ch0_sel;
      tad_tick = (tad_cnt_r == i_ctl_three[`SADC_C3_TAD_HI:`SADC_C3_TAD_LO]);
      samc_done = (samc_cnt_r >= i_ctl_three[`SADC_C3_SAMC_HI:`SADC_C3_SAMC_LO])
                  && (samc_cnt_r != 5'h00);
      case (ssrc)
         `SADC_SSRC_MANUAL: trig = i_samp_clear;
         `SADC_SSRC_AUTO:   trig = samc_done;
         default:           trig = i_trig_src[ssrc];
      endcase

      slot_mask = (`SADC_ADDR_W'(1) << i_dma_buf_len) - `SADC_ADDR_W'(1);
      if (i_ctl_one[`SADC_C1_BUILD]) begin
         if (i_ctl_two[`SADC_C2_BUFM]) begin
            addr = {{(`SADC_ADDR_W - `SADC_HALF_W - 1){1'b0}}, half_r,
                    grp_r[`SADC_HALF_W-1:0]};
         end else begin
            addr = {{(`SADC_ADDR_W - 4){1'b0}}, grp_r};
         end
      end else begin
         addr = (`SADC_ADDR_W'(ain_r) << i_dma_buf_len)
                | (`SADC_ADDR_W'(ptr_r) & slot_mask);
      end

      state_nxt    = state_r;
      samc_cnt_nxt = samc_cnt_r;
      bit_nxt      = bit_r;
      sh_nxt       = sh_r;
      scan_nxt     = scan_r;
      dac_nxt      = dac_r;
      grp_nxt      = grp_r;
      ptr_nxt      = ptr_r;
      half_nxt     = half_r;
      ain_nxt      = ain_r;
      track_nxt    = track_r;
      req_nxt      = 1'b0;
      fifo_in_valid = 1'b0;
      vref_nxt     = i_ctl_two[`SADC_C2_VREF_HI:`SADC_C2_VREF_LO];
      // Latched only while off, so a change with the module on waits
      res_hi_nxt   = on ? res_hi_r : i_ctl_one[`SADC_C1_RES];
      flag_nxt     = flag_r && !i_flag_clear;
      tad_cnt_nxt  = (!run || tad_tick || state_r == sadc_pkg::SADC_IDLE) ? 8'h00
                     : tad_cnt_r + 8'h01;

      case (state_r)
         sadc_pkg::SADC_IDLE: begin
            track_nxt = 4'h0;
            if (run && (i_ctl_one[`SADC_C1_ASAM] || i_samp_set)) begin
               state_nxt    = sadc_pkg::SADC_TRACK;
               samc_cnt_nxt = 5'h00;
               track_nxt    = sh_mask;
               ain_nxt      = ch0_ain;
            end
         end
         sadc_pkg::SADC_TRACK: begin
            if (tad_tick && !samc_done) begin
               samc_cnt_nxt = samc_cnt_r + 5'h01;
            end
            if (!run) begin
               state_nxt = sadc_pkg::SADC_IDLE;
            end else if (trig) begin
               // All enabled holds freeze together, then convert in turn
               track_nxt = 4'h0;
               sh_nxt    = 2'h0;
               bit_nxt   = nbits_m1;
               dac_nxt   = 12'h001 << nbits_m1;
               ain_nxt   = ch0_ain;
               state_nxt = sadc_pkg::SADC_CONV;
            end
         end
         sadc_pkg::SADC_CONV: begin
            if (!run) begin
               state_nxt = sadc_pkg::SADC_IDLE;
            end else if (tad_tick) begin
               if (!i_cmp) begin
                  dac_nxt[bit_r] = 1'b0;
               end
               if (bit_r == 4'h0) begin
                  state_nxt = sadc_pkg::SADC_STORE;
               end else begin
                  bit_nxt = bit_r - 4'h1;
                  dac_nxt[bit_r - 4'h1] = 1'b1;
               end
            end
         end
         sadc_pkg::SADC_STORE: begin
            // Stalls here while the FIFO is full
            fifo_in_valid = 1'b1;
            if (fifo_in_ready) begin
               if (grp_r == i_ctl_two[`SADC_C2_RATE_HI:`SADC_C2_RATE_LO]) begin
                  grp_nxt  = 4'h0;
                  ptr_nxt  = ptr_r + 7'h01;
                  flag_nxt = 1'b1;
                  req_nxt  = 1'b1;
                  half_nxt = i_ctl_two[`SADC_C2_BUFM] ? !half_r : 1'b0;
               end else begin
                  grp_nxt = grp_r + 4'h1;
               end
               if (sh_r == nsh_m1) begin
                  if (i_ctl_two[`SADC_C2_SCAN]) begin
                     scan_nxt = next_scan(scan_r, analog);
                  end
                  if (run && i_ctl_one[`SADC_C1_ASAM]) begin
                     state_nxt    = sadc_pkg::SADC_TRACK;
                     samc_cnt_nxt = 5'h00;
                     track_nxt    = sh_mask;
                     ain_nxt      = i_ctl_two[`SADC_C2_SCAN]
                                    ? next_scan(scan_r, analog) : i_ch0_sel;
                  end else begin
                     state_nxt = sadc_pkg::SADC_IDLE;
                  end
               end else begin
                  sh_nxt    = sh_r + 2'h1;
                  ain_nxt   = ain_of(sh_r + 2'h1, ch0_ain, i_ch123_alt);
                  bit_nxt   = nbits_m1;
                  dac_nxt   = 12'h001 << nbits_m1;
                  state_nxt = sadc_pkg::SADC_CONV;
               end
            end
         end
         default: begin
            state_nxt = sadc_pkg::SADC_IDLE;
         end
      endcase
      if (!on) begin
         grp_nxt  = 4'h0;
         ptr_nxt  = 7'h00;
         half_nxt = 1'b0;
      end

      // Registered so the port comes straight from a flip-flop
      busy_nxt = (state_nxt == sadc_pkg::SADC_CONV) || (state_nxt == sadc_pkg::SADC_STORE);
      fifo_out_ready = !ovalid_r || i_dma_ready;
      ovalid_nxt     = ovalid_r && !i_dma_ready;
      oword_nxt      = oword_r;
      if (fifo_out_valid && fifo_out_ready) begin
         ovalid_nxt = 1'b1;
         oword_nxt  = fifo_out_data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_r    <= sadc_pkg::SADC_IDLE;
         tad_cnt_r  <= 8'h00;
         samc_cnt_r <= 5'h00;
         bit_r      <= 4'h0;
         sh_r       <= 2'h0;
         scan_r     <= 5'h00;
         dac_r      <= 12'h000;
         grp_r      <= 4'h0;
         ptr_r      <= 7'h00;
         half_r     <= 1'b0;
         res_hi_r   <= 1'b0;
         flag_r     <= 1'b0;
         req_r      <= 1'b0;
         ain_r      <= 5'h00;
         track_r    <= 4'h0;
         vref_r     <= 3'h0;
         ovalid_r   <= 1'b0;
         oword_r    <= '0;
         busy_r     <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         tad_cnt_r  <= tad_cnt_nxt;
         samc_cnt_r <= samc_cnt_nxt;
         bit_r      <= bit_nxt;
         sh_r       <= sh_nxt;
         scan_r     <= scan_nxt;
         dac_r      <= dac_nxt;
         grp_r      <= grp_nxt;
         ptr_r      <= ptr_nxt;
         half_r     <= half_nxt;
         res_hi_r   <= res_hi_nxt;
         flag_r     <= flag_nxt;
         req_r      <= req_nxt;
         ain_r      <= ain_nxt;
         track_r    <= track_nxt;
         vref_r     <= vref_nxt;
         ovalid_r   <= ovalid_nxt;
         oword_r    <= oword_nxt;
         busy_r     <= busy_nxt;
      end
   end

   sadc_fifo #(
      .W     (FW),
      .DEPTH (`SADC_FIFO_DEPTH)
   ) u_fifo (
      .i_clk       (i_clk),
      .i_rst       (i_rst),
      .i_in_valid  (fifo_in_valid),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   ({addr, fmt(dac_r, i_ctl_one[`SADC_C1_FORM_HI:`SADC_C1_FORM_LO],
                                res_hi_r)}),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (fifo_out_ready),
      .o_out_data  (fifo_out_data)
   );

   assign o_ain_sel  = ain_r;
   assign o_sh_track = track_r;
   assign o_dac_code = dac_r;
   assign o_vref_sel = vref_r;
   assign o_busy     = busy_r;
   assign o_converter_interrupt_flag = flag_r;
   assign o_dma_req  = req_r;
   assign o_dma_valid = ovalid_r;
   assign o_dma_data = oword_r[`SADC_DATA_W-1:0];
   assign o_dma_addr = oword_r[FW-1:`SADC_DATA_W];
endmodule : sadc_ctrl

`default_nettype wire

// *** hw/sadc_fifo.sv ***
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none

module sadc_fifo #(
   parameter int W     = 28,
   parameter int DEPTH = 16
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic         i_in_valid,
   output logic              o_in_ready,
   input  wire logic [W-1:0] i_in_data,
   output logic              o_out_valid,
   input  wire logic         i_out_ready,
   output logic [W-1:0]      o_out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wr_r;
   logic [AW:0]  wr_nxt;
   logic [AW:0]  rd_r;
   logic [AW:0]  rd_nxt;
   logic         push;
   logic         pop;
   logic         full;
   logic         empty;

   always_comb begin
      empty  = (wr_r == rd_r);
      full   = (wr_r[AW-1:0] == rd_r[AW-1:0]) && (wr_r[AW] != rd_r[AW]);
      push   = i_in_valid && !full;
      pop    = i_out_ready && !empty;
      wr_nxt = push ? wr_r + 1'b1 : wr_r;
      rd_nxt = pop ? rd_r + 1'b1 : rd_r;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
      end
      if (push) begin
         mem[wr_r[AW-1:0]] <= i_in_data;
      end
   end

   assign o_in_ready  = !full;
   assign o_out_valid = !empty;
   assign o_out_data  = mem[rd_r[AW-1:0]];
endmodule : sadc_fifo

`default_nettype wire

// *** shared/sadc_map.svh ***
/*
 Constants of the converter control block: control word fields,
 result bit counts, trigger codes and buffer sizes.
 Assumes it is included by its bare name after sadc_pkg.
*/
`ifndef SADC_MAP_SVH
`define SADC_MAP_SVH

`define SADC_C1_ON        15
`define SADC_C1_SIDL      13
`define SADC_C1_BUILD     12
`define SADC_C1_RES       10
`define SADC_C1_FORM_HI   9
`define SADC_C1_FORM_LO   8
`define SADC_C1_SSRC_HI   7
`define SADC_C1_SSRC_LO   5
`define SADC_C1_ASAM      2

`define SADC_C2_VREF_HI   15
`define SADC_C2_VREF_LO   13
`define SADC_C2_SCAN      10
`define SADC_C2_CHPS_HI   9
`define SADC_C2_CHPS_LO   8
`define SADC_C2_RATE_HI   5
`define SADC_C2_RATE_LO   2
`define SADC_C2_BUFM      1

`define SADC_C3_SAMC_HI   12
`define SADC_C3_SAMC_LO   8
`define SADC_C3_TAD_HI    7
`define SADC_C3_TAD_LO    0

`define SADC_SSRC_MANUAL  3'h0
`define SADC_SSRC_AUTO    3'h7

`define SADC_BITS_LO_M1   4'h9
`define SADC_BITS_HI_M1   4'hb

`define SADC_DATA_W       16
`define SADC_ADDR_W       12
`define SADC_FIFO_DEPTH   16
`define SADC_HALF_W       3

`endif

// *** shared/sadc_pkg.sv ***
/*
 Types of the converter control block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package sadc_pkg;
   typedef enum logic [1:0] {
      SADC_IDLE,
      SADC_TRACK,
      SADC_CONV,
      SADC_STORE
   } sadc_state_t;
endpackage : sadc_pkg
